// file: core/serial_flash_write_guard.v
// write protection and power-state gating of a serial flash
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
`include "write_guard_defs.vh"

// Behaviour
// R1: select low means selected and active
// R2: stay active until internal cycles finish
// R3: sleep command enters, wake command leaves
// R4: deep power-down ignores all modifying commands
// R5: modifying command needs clock count multiple eight
// R6: modifying commands need write enable latch
// R7: block modifications until power-up delay expires
// R8: one guard/freeze lock register per sector
// R9: guard bit set fails program/erase there
// R10: freeze bit locks guard/freeze until power-up
// R11: protect pin freezes protect level, disable bit
// R12: bulk erase only with protect level zero
// R13: 16 sectors, top: protect upper areas
// R14: 16 sectors, bottom: protect lower areas
// R15: 32 sectors, top: protect upper areas
// R16: 32 sectors, bottom: protect lower areas
// R17: 64 sectors, top: codes 000 to 010
// R18: 64 sectors, top: codes 011 to 111
// R19: 64 sectors, bottom: protect lower areas
// R20: area or guard bit alone refuses
// R21: power-up clears every freeze bit
module serial_flash_write_guard (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        spi_sclk,
  input  wire        spi_cs_n,
  input  wire        spi_mosi,
  input  wire        wp_n,
  input  wire        engine_busy,
  output reg         grant_program,
  output reg         grant_erase,
  output reg         grant_bulk,
  output reg         refuse_pulse,
  output reg  [5:0]  op_sector,
  output reg         power_active,
  output reg         deep_power_down
);

  reg  [2:0]  sclk_s;
  reg  [2:0]  cs_s;
  reg  [1:0]  mosi_s;
  reg  [1:0]  wp_s;
  reg  [39:0] shift_reg;
  reg  [5:0]  bit_total;
  reg  [2:0]  bit_mod;
  reg  [10:0] puw_cnt;
  reg         pu_done_reg;
  reg         wel_reg;
  reg  [2:0]  bp_reg;
  reg         tb_reg;
  reg         status_write_disable_bit_reg;
  reg  [1:0]  dens_reg;
  reg  [5:0]  lock_sel_reg;
  reg  [63:0] guard_reg;
  reg  [63:0] freeze_reg;
  reg         last_ok_reg;
  reg         last_ref_reg;
  wire [63:0] guard_next;
  wire [63:0] freeze_next;

  wire sclk_rise = (sclk_s[2:1] == 2'b01);
  wire frame_end = (cs_s[2:1] == 2'b01);
  wire selected  = ~cs_s[1];
  wire wp_on     = ~wp_s[1];
  wire [7:0] opcode   = shift_reg[39:32];
  wire [7:0] sr_data  = shift_reg[31:24];
  wire [5:0] addr_sec = shift_reg[29:24];
  wire [7:0] tail     = shift_reg[7:0];

  // read words built from field positions, so layout lives in one place
  reg  [7:0]  status_byte;
  reg  [4:0]  state_bits;
  reg  [1:0]  lock_bits;
  always @* begin
    status_byte                        = 8'h00;
    status_byte[`SR_WIP]               = engine_busy;
    status_byte[`SR_WEL]               = wel_reg;
    status_byte[`SR_BP_MSB:`SR_BP_LSB] = bp_reg;
    status_byte[`SR_TB]                = tb_reg;
    status_byte[`SR_STATUS_WRITE_DISABLE_BIT]              = status_write_disable_bit_reg;
    state_bits                         = 5'h00;
    state_bits[`ST_ACTIVE]             = power_active;
    state_bits[`ST_DEEP]               = deep_power_down;
    state_bits[`ST_PU_DONE]            = pu_done_reg;
    state_bits[`ST_LAST_OK]            = last_ok_reg;
    state_bits[`ST_LAST_REF]           = last_ref_reg;
    lock_bits                          = 2'h0;
    lock_bits[`LOCK_GUARD_BIT]         = guard_reg[lock_sel_reg];
    lock_bits[`LOCK_FREEZE_BIT]        = freeze_reg[lock_sel_reg];
  end

  // area decode shared by all densities; density picks size and all-level
  function area_prot;
    input [2:0] bp;
    input       tb;
    input [1:0] dens;
    input [5:0] sec;
    reg   [6:0] n;
    reg   [6:0] mask;
    reg   [6:0] cnt;
    reg   [6:0] s;
    begin
      n    = 7'h10 << dens;
      mask = n - 7'h01;
      s    = {1'b0, sec} & mask;
      cnt  = 7'h01 << (bp - 3'h1);
      if (bp == 3'h0) begin
        area_prot = 1'b0; // R13 R14 R15 R16 R17 R19
      end else if ({1'b0, bp} >= (4'h5 + {2'h0, dens})) begin
        area_prot = 1'b1; // R13 R14 R15 R16 R18 R19
      end else if (tb) begin
        area_prot = (s < cnt); // R14 R16 R19
      end else begin
        area_prot = (s >= (n - cnt)); // R13 R15 R17 R18
      end
    end
  endfunction

  // pins are asynchronous to ref_clk; edge detect looks at stages 1 and 2 only
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= 3'h0;
      cs_s   <= 3'h7;
      mosi_s <= 2'h0;
      wp_s   <= 2'h3;
    end else begin
      sclk_s <= {sclk_s[1:0], spi_sclk};
      cs_s   <= {cs_s[1:0], spi_cs_n};
      mosi_s <= {mosi_s[0], spi_mosi};
      wp_s   <= {wp_s[0], wp_n};
    end
  end

  // frame capture, left aligned so short commands still find the opcode
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 40'h0;
      bit_total <= 6'h0;
      bit_mod   <= 3'h0;
    end else if (frame_end) begin
      shift_reg <= 40'h0;
      bit_total <= 6'h0;
      bit_mod   <= 3'h0;
    end else if (selected && sclk_rise) begin
      if (bit_total < `FRAME_BITS) begin
        shift_reg[6'h27 - bit_total] <= mosi_s[1];
      end
      // saturate so an overlong frame cannot wrap into a short one
      if (bit_total != 6'h3F) begin
        bit_total <= bit_total + 6'h01;
      end
      bit_mod <= bit_mod + 3'h1; // R5
    end
  end

  // power-up write delay after reset release
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      puw_cnt     <= 11'h0;
      pu_done_reg <= 1'b0;
    end else if (!pu_done_reg) begin
      // halts once done, so it cannot wrap and reopen the gate
      if (puw_cnt == `PUW_CYCLES - 1) begin
        pu_done_reg <= 1'b1; // R7
      end
      puw_cnt <= puw_cnt + 11'h001;
    end
  end

  // command judgement at frame end
  reg is_mod;
  reg is_prog;
  reg is_erase;
  reg is_bulk;
  reg gate_ok;
  reg target_prot;
  always @* begin
    is_prog  = (opcode == `OP_PP) || (opcode == `OP_DIFP);
    is_erase = (opcode == `OP_SE) || (opcode == `OP_SSE);
    is_bulk  = (opcode == `OP_BE);
    is_mod   = is_prog || is_erase || is_bulk || (opcode == `OP_WRSR) ||
               (opcode == `OP_WRLOCK);
    gate_ok  = (bit_mod == 3'h0) && (bit_total != 6'h0) && // R5
               wel_reg &&                                  // R6
               pu_done_reg &&                              // R7
               !deep_power_down &&                         // R4
               !engine_busy;
    target_prot = area_prot(bp_reg, tb_reg, dens_reg, addr_sec) || // R20
                  guard_reg[addr_sec];                             // R9
  end

  wire judge     = frame_end && (bit_total != 6'h0);
  wire mod_ok    = judge && is_mod && gate_ok;
  wire ok_prog   = mod_ok && is_prog && !target_prot;
  wire ok_erase  = mod_ok && is_erase && !target_prot;
  wire ok_bulk   = mod_ok && is_bulk && (bp_reg == 3'h0); // R12
  wire ok_wrsr   = mod_ok && (opcode == `OP_WRSR);
  wire ok_lock   = mod_ok && (opcode == `OP_WRLOCK);
  wire accepted  = ok_prog || ok_erase || ok_bulk || ok_wrsr || ok_lock;
  // a sleeping device stays silent: no refusal pulse either
  wire refused   = judge && is_mod && !accepted && !deep_power_down;
  wire plain_ok  = judge && (bit_mod == 3'h0) && !deep_power_down;
  // wake must be heard while asleep, so it skips the sleep gate
  wire wake_ok   = judge && (bit_mod == 3'h0) && (opcode == `OP_RES);

  // per-sector lock registers; a frozen sector ignores the write
  genvar i;
  generate
    for (i = 0; i < 64; i = i + 1) begin : g_lock
      wire hit = ok_lock && (addr_sec == i) && !freeze_reg[i]; // R10
      assign guard_next[i]  = hit ? tail[`LOCK_GUARD_BIT] : guard_reg[i]; // R8
      assign freeze_next[i] = hit ? tail[`LOCK_FREEZE_BIT] : freeze_reg[i];
    end
  endgenerate

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      guard_reg  <= 64'h0;
      freeze_reg <= 64'h0; // R21
    end else begin
      guard_reg  <= guard_next; // R8
      freeze_reg <= freeze_next;
    end
  end

  // active while selected, and after deselect while the engine works
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_active <= 1'b0;
    end else begin
      power_active <= selected || engine_busy; // R1 R2
    end
  end

  // status byte, write enable latch and power state
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_reg         <= 1'b0;
      bp_reg          <= `SR_BP_RST;
      tb_reg          <= 1'b0;
      status_write_disable_bit_reg        <= 1'b0;
      deep_power_down <= 1'b0;
    end else begin
      if (wake_ok) begin
        deep_power_down <= 1'b0; // R3
      end else if (plain_ok && (opcode == `OP_DP)) begin
        deep_power_down <= 1'b1; // R3
      end
      if (plain_ok && (opcode == `OP_WREN)) begin
        wel_reg <= 1'b1; // R6
      end else if ((plain_ok && (opcode == `OP_WRDI)) || accepted) begin
        wel_reg <= 1'b0;
      end
      if (ok_wrsr) begin
        tb_reg <= sr_data[`SR_TB];
        if (!wp_on) begin
          bp_reg   <= sr_data[`SR_BP_MSB:`SR_BP_LSB]; // R11
          status_write_disable_bit_reg <= sr_data[`SR_STATUS_WRITE_DISABLE_BIT];
        end
      end
    end
  end

  // grants and refusals, one-cycle pulses
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      grant_program <= 1'b0;
      grant_erase   <= 1'b0;
      grant_bulk    <= 1'b0;
      refuse_pulse  <= 1'b0;
      op_sector     <= 6'h0;
      last_ok_reg   <= 1'b0;
      last_ref_reg  <= 1'b0;
    end else begin
      grant_program <= ok_prog;  // R20
      grant_erase   <= ok_erase; // R20
      grant_bulk    <= ok_bulk;
      refuse_pulse  <= refused;  // R9
      if (judge && is_mod) begin
        op_sector    <= addr_sec;
        last_ok_reg  <= accepted;
        last_ref_reg <= refused;
      end
    end
  end

  // avalon slave: one wait cycle, then the access completes
  wire req = avs_read || avs_write;
  reg [31:0] rd_mux;
  always @* begin
    case (avs_address)
      `OFF_CONFIG:      rd_mux = {30'h0, dens_reg};
      `OFF_STATUS_BYTE: rd_mux = {24'h0, status_byte};
      `OFF_STATE:       rd_mux = {27'h0, state_bits};
      `OFF_LOCK_SEL:    rd_mux = {26'h0, lock_sel_reg};
      `OFF_LOCK_VAL:    rd_mux = {30'h0, lock_bits};
      default:          rd_mux = 32'h0;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      dens_reg        <= `CFG_DENS_RST;
      lock_sel_reg    <= 6'h0;
    end else begin
      if (req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
      if (avs_write && !avs_waitrequest) begin
        if (avs_address == `OFF_CONFIG) begin
          // density 3 is not a real part; clamp to the largest
          if (avs_writedata[`CFG_DENS_MSB:`CFG_DENS_LSB] > `CFG_DENS_MAX) begin
            dens_reg <= `CFG_DENS_MAX;
          end else begin
            dens_reg <= avs_writedata[`CFG_DENS_MSB:`CFG_DENS_LSB];
          end
        end
        if (avs_address == `OFF_LOCK_SEL) begin
          lock_sel_reg <= avs_writedata[5:0];
        end
      end
    end
  end

endmodule

// file: pkg/write_guard_defs.vh
// constants for the serial flash write guard
`ifndef WRITE_GUARD_DEFS_VH
`define WRITE_GUARD_DEFS_VH
// register byte offsets
`define OFF_CONFIG      6'h00
`define OFF_STATUS_BYTE 6'h04
`define OFF_STATE       6'h08
`define OFF_LOCK_SEL    6'h0C
`define OFF_LOCK_VAL    6'h10
// config fields and reset values
`define CFG_DENS_MSB    1
`define CFG_DENS_LSB    0
`define CFG_DENS_RST    2'h2
`define CFG_DENS_MAX    2'h2
// status byte fields
`define SR_WIP          0
`define SR_WEL          1
`define SR_BP_MSB       4
`define SR_BP_LSB       2
`define SR_TB           5
`define SR_STATUS_WRITE_DISABLE_BIT         7
`define SR_BP_RST       3'h0
// state register fields
`define ST_ACTIVE       0
`define ST_DEEP         1
`define ST_PU_DONE      2
`define ST_LAST_OK      3
`define ST_LAST_REF     4
// lock data bits
`define LOCK_GUARD_BIT  0
`define LOCK_FREEZE_BIT 1
// opcodes
`define OP_WREN         8'h06
`define OP_WRDI         8'h04
`define OP_WRSR         8'h01
`define OP_PP           8'h02
`define OP_DIFP         8'hA2
`define OP_SSE          8'h20
`define OP_SE           8'hD8
`define OP_BE           8'hC7
`define OP_DP           8'hB9
`define OP_RES          8'hAB
`define OP_WRLOCK       8'hE5
// frame capture length in bits
`define FRAME_BITS      6'h28
// power-up write delay
`define PUW_TIME_US     10
`define CLK_MHZ         125
`define PUW_CYCLES      (`PUW_TIME_US * `CLK_MHZ)
`endif

// file: bench/write_guard_checker_assertions.sv
// port-level assertions for the serial flash write guard
`timescale 1ns/1ns
`include "write_guard_defs.vh"
module write_guard_checker (
  input wire ref_clk,
  input wire rst_n,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire spi_cs_n,
  input wire engine_busy,
  input wire grant_program,
  input wire grant_erase,
  input wire grant_bulk,
  input wire refuse_pulse,
  input wire power_active,
  input wire deep_power_down
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [10:0] pu_cnt;
  wire         any_grant = grant_program | grant_erase | grant_bulk;
  // saturating count of cycles since power-on
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      pu_cnt <= 11'h000;
    else if (pu_cnt < `PUW_CYCLES)
      pu_cnt <= pu_cnt + 11'h001;
  sequence req_open;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence idle_link;
    (spi_cs_n && !engine_busy) [*6];
  endsequence
  ack_next_a: assert property (req_open |=> !avs_waitrequest) else $error("ack late");
  ack_short_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack long");
  puw_block_a: assert property (any_grant |-> pu_cnt >= `PUW_CYCLES) else $error("early");
  deep_quiet_a: assert property (deep_power_down && $past(deep_power_down)
    |-> !(any_grant || refuse_pulse)) else $error("deep pulse");
  sel_active_a: assert property (!spi_cs_n [*5] |-> power_active) else $error("sel");
  busy_active_a: assert property (engine_busy |=> power_active) else $error("busy");
  standby_a: assert property (idle_link |-> !power_active) else $error("standby");
  judge_end_a: assert property ((any_grant || refuse_pulse) |-> $past(spi_cs_n, 2))
    else $error("judge in frame");
  one_verdict_a: assert property ($onehot0({any_grant, refuse_pulse}))
    else $error("two verdicts");
endmodule
bind serial_flash_write_guard write_guard_checker chk_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .spi_cs_n(spi_cs_n), .engine_busy(engine_busy),
  .grant_program(grant_program), .grant_erase(grant_erase), .grant_bulk(grant_bulk),
  .refuse_pulse(refuse_pulse), .power_active(power_active),
  .deep_power_down(deep_power_down));

// file: bench/spi_host_model.sv
// serial bus master model driving the guard's link pins
`timescale 1ns/1ns
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // clock idles low; data set while low, msb first
  task send(input [47:0] f, input integer n);
    integer i;
    begin
      cs_n = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        mosi = f[47-i];
        #80 sclk = 1'b1;
        #80 sclk = 1'b0;
      end
      #80 cs_n = 1'b1;
      mosi = ~mosi;
    end
  endtask
endmodule

// file: bench/serial_flash_write_guard_tb_top.sv
// self-checking bench for the serial flash write guard
`timescale 1ns/1ns
`include "write_guard_defs.vh"
module serial_flash_write_guard_tb_top;
  logic ref_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic wp_n = 1'b1, engine_busy = 1'b0, tb, sclk, cs_n, mosi, wq, gp, ge, gb, rf, pa, dp;
  logic [5:0] avs_address = 6'h00, sc, op_sector;
  logic [31:0] avs_writedata = 32'h0, rdata, q, seed = 32'h7B55E196;
  logic [3:0] seen = 4'h0;
  logic [2:0] bp;
  logic [1:0] dn;
  integer n_mismatch = 0, compares = 0, i;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) seen <= seen | {gp, ge, gb, rf};
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  serial_flash_write_guard DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(rdata), .avs_waitrequest(wq), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .wp_n(wp_n), .engine_busy(engine_busy), .grant_program(gp),
    .grant_erase(ge), .grant_bulk(gb), .refuse_pulse(rf), .op_sector(op_sector),
    .power_active(pa), .deep_power_down(dp));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function prot(input [1:0] d, input t, input [2:0] b, input [5:0] s);
    integer n, z;
    begin
      n = 16 << d;
      z = (b == 3'h0) ? 0 : (1 << (b - 1));
      if (z > n)
        z = n;
      prot = t ? (s < z) : (s >= n - z);
    end
  endfunction
  function [47:0] fr(input [7:0] op, input [5:0] s, input [7:0] d);
    fr = {op, 2'b00, s, 16'h0000, d, 8'h00};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("mismatches=%0d compares=%0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task av(input w, input [5:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      k = 0;
      // look mid-cycle, away from the edge that moves waitrequest
      @(negedge ref_clk);
      while (wq !== 1'b0 && k < 20) begin
        @(negedge ref_clk);
        k = k + 1;
      end
      if (k == 20) begin
        n_mismatch = n_mismatch + 1;
        report_and_stop;
      end
      @(posedge ref_clk);
      q = rdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  // verdict lands a few cycles after the synchronised deselect
  task cmd(input [47:0] f, input integer n, input [3:0] e);
    begin
      @(negedge ref_clk);
      seen = 4'h0;
      host.send(f, n);
      repeat (12) @(posedge ref_clk);
      chk(seen, e);
    end
  endtask
  task wcmd(input [47:0] f, input integer n, input [3:0] e);
    begin
      cmd({`OP_WREN, 40'h0}, 8, 4'h0);
      cmd(f, n, e);
    end
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    av(0, `OFF_CONFIG, 0);
    chk(q, 2);
    av(1, `OFF_STATUS_BYTE, 32'hFF);
    av(0, `OFF_STATUS_BYTE, 0);
    chk(q, 0);
    av(0, 6'h14, 0);
    chk(q, 0);
    wcmd(fr(`OP_SE, 0, 0), 32, 1);
    i = 0;
    q = 0;
    while (q[`ST_PU_DONE] !== 1'b1 && i < 1000) begin
      av(0, `OFF_STATE, 0);
      i = i + 1;
    end
    chk(i < 1000, 1);
    if (i == 1000)
      report_and_stop;
    cmd({`OP_WRDI, 40'h0}, 8, 0);
    cmd(fr(`OP_SE, 1, 0), 32, 1);
    wcmd(fr(`OP_SE, 1, 0), 33, 1);
    wcmd(fr(`OP_PP, 1, 0), 40, 8);
    for (i = 0; i < 14; i = i + 1) begin
      seed = lfsr(seed);
      dn = seed[1:0] % 2'd3;
      bp = (i < 2) ? 3'h1 : seed[4:2];
      tb = (i < 2) ? i[0] : seed[5];
      sc = seed[11:6] & ((16 << dn) - 1);
      if (i < 2)
        sc = tb ? 6'h00 : (16 << dn) - 1;
      av(1, `OFF_CONFIG, dn);
      wcmd(fr(`OP_WRSR, {tb, bp, 2'b00}, 0), 16, 0);
      av(0, `OFF_STATUS_BYTE, 0);
      chk(q, {tb, bp, 2'b00});
      wcmd(fr(`OP_SE, sc, 0), 32, prot(dn, tb, bp, sc) ? 1 : 4);
      wcmd({`OP_BE, 40'h0}, 8, (bp == 3'h0) ? 2 : 1);
    end
    av(1, `OFF_CONFIG, 3);
    av(0, `OFF_CONFIG, 0);
    chk(q, 2);
    wcmd(fr(`OP_WRSR, 0, 0), 16, 0);
    wcmd(fr(`OP_WRLOCK, 5, 3), 40, 0);
    av(1, `OFF_LOCK_SEL, 5);
    av(0, `OFF_LOCK_VAL, 0);
    chk(q, 3);
    wcmd(fr(`OP_SE, 5, 0), 32, 1);
    wcmd(fr(`OP_WRLOCK, 5, 0), 40, 0);
    av(0, `OFF_LOCK_VAL, 0);
    chk(q, 3);
    wcmd(fr(`OP_SE, 6, 0), 32, 4);
    chk(op_sector, 6);
    wcmd(fr(`OP_SSE, 7, 0), 32, 4);
    wcmd(fr(`OP_DIFP, 5, 0), 40, 1);
    wp_n <= 1'b0;
    wcmd(fr(`OP_WRSR, 6'h1C, 0), 16, 0);
    av(0, `OFF_STATUS_BYTE, 0);
    chk(q & 32'hFD, 0);
    wp_n <= 1'b1;
    cmd({`OP_DP, 40'h0}, 8, 0);
    chk(dp, 1);
    wcmd(fr(`OP_SE, 6, 0), 32, 0);
    cmd({`OP_RES, 40'h0}, 8, 0);
    chk(dp, 0);
    engine_busy <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(pa, 1);
    engine_busy <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(pa, 0);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    av(1, `OFF_LOCK_SEL, 5);
    av(0, `OFF_LOCK_VAL, 0);
    chk(q, 0);
    report_and_stop;
  end
endmodule
